// ---- bench/prc_config_top_bench.sv ----
// prc_config_top_bench: self-checking bench for the paged configuration block
`timescale 1ns/10ps
module prc_config_top_bench;
    import prc_pkg::*;
    logic          clk, rst_n, sck, ss_n, mosi, miso, miso_oe_n;
    prc_strap_type if_strap, lb_strap, cab_strap;
    logic [7:0]    eye_score, rd_data;
    logic          eye_score_valid, rate_supported;
    logic [4:0]    eq_boost_q;
    logic          eye_monitor_en, cdr_lock_q, reclock_bypass_q;
    logic          smbus_mode_q, loopback_output_en_q, second_cable_output_en_q;
    logic [16:0]   rx_word;
    int            n_mismatch, samples_checked, cycles;

    prc_config_top #(.DWELL_CYCLES(4)) u_prc_config_top (.clk(clk), .rst_n(rst_n),
        .interface_select_strap(if_strap), .loopback_output_select_strap(lb_strap),
        .second_cable_select_strap(cab_strap), .sck(sck), .ss_n(ss_n), .mosi(mosi), .miso(miso),
        .miso_oe_n(miso_oe_n), .eye_score(eye_score), .eye_score_valid(eye_score_valid),
        .rate_supported(rate_supported), .eq_boost_q(eq_boost_q), .eye_monitor_en(eye_monitor_en),
        .cdr_lock_q(cdr_lock_q), .reclock_bypass_q(reclock_bypass_q), .smbus_mode_q(smbus_mode_q),
        .loopback_output_en_q(loopback_output_en_q), .second_cable_output_en_q(second_cable_output_en_q));
    prc_host_model u_prc_host_model (.clk(clk), .sck(sck), .ss_n(ss_n), .mosi(mosi), .miso(miso));

    // clock and time-zero inputs
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial
    begin
        rst_n = 1'b0;
        // enum targets take whole enum values, never slices of a concatenation
        if_strap = STRAP_F;
        lb_strap = STRAP_F;
        cab_strap = STRAP_F;
        rate_supported = 1'b1;
        eye_score = 8'h00;
        eye_score_valid = 1'b1;
    end

    // eye figure peaks twice (boost 9 and 20) so the first maximum must win
    always @(posedge clk)
        eye_score <= (eq_boost_q == 5'h09 || eq_boost_q == 5'h14) ? 8'hf0 : {3'h0, eq_boost_q};

    // hang guard well above the few thousand cycles the run needs
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            n_mismatch++;
            complete_run();
        end
    end

    task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // straps are caught at the first edge after release
    task automatic do_reset(input prc_strap_type s);
        rst_n <= 1'b0;
        if_strap <= s;
        lb_strap <= s;
        cab_strap <= s;
        repeat (8) @(posedge clk);
        chk(17'(cdr_lock_q), 17'h0);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_prc_host_model.xfer({1'b0, a, d}, rx_word);
    endtask

    // address frame, then a dummy frame that carries the reply out
    task automatic rd(input logic [7:0] a);
        // data pin is enabled inside the frame and released after it
        fork
            u_prc_host_model.xfer({1'b1, a, 8'hff}, rx_word);
            begin
                repeat (4) @(posedge clk);
                chk(17'(miso_oe_n), 17'h0);
            end
        join
        u_prc_host_model.xfer({1'b1, 8'hff, 8'hff}, rx_word);
        chk(17'(miso_oe_n), 17'h1);
        chk(17'(rx_word[16:8]), 17'({1'b1, a}));
        rd_data = rx_word[7:0];
    endtask

    task automatic wait_lock();
        for (int i = 0; i < 600 && cdr_lock_q !== 1'b1; i++)
            @(posedge clk);
        chk(17'(cdr_lock_q), 17'h1);
    endtask

    task automatic t_straps();
        for (int i = 0; i < 4; i++)
        begin
            do_reset(prc_strap_type'(i));
            chk(17'(smbus_mode_q), 17'(i < 2));
            chk(17'(loopback_output_en_q), 17'(i != 3));
            chk(17'(second_cable_output_en_q), 17'(i == 0));
            if (i == 0)
            begin
                // two-wire mode: the serial data pin must stay released mid-frame
                fork
                    wr(8'hff, 8'h04);
                    begin
                        repeat (4) @(posedge clk);
                        chk(17'(miso_oe_n), 17'h1);
                    end
                join
                wr(8'h3e, 8'h00);
                chk(17'(eye_monitor_en), 17'h1);
            end
        end
    endtask

    task automatic t_adaptive();
        wait_lock();
        chk(17'(eq_boost_q), 17'h09);
        rd(8'h02);
        chk(17'(rd_data & 8'h07), 17'h01);
        wr(8'hff, 8'h04);
        wr(8'h3e, 8'h00);                                    // cleared only after lock
        repeat (2) @(posedge clk);
        chk(17'(eye_monitor_en), 17'h0);
        repeat (100) @(posedge clk);
        chk(17'(cdr_lock_q), 17'h1);
    endtask

    task automatic t_pages();
        wr(8'hff, 8'h05);
        wr(8'h3e, 8'ha5);
        rd(8'h3e);
        chk(17'(rd_data), 17'ha5);
        chk(17'(eye_monitor_en), 17'h0);
        wr(8'hff, 8'h04);
        rd(8'h3e);
        chk(17'(rd_data), 17'h00);
        wr(8'h3e, 8'h80);
        chk(17'(eye_monitor_en), 17'h1);
        wr(8'hff, 8'h02);
        rd(8'h3e);
        chk(17'(rd_data), 17'h00);
        rd(8'hff);
        chk(17'(rd_data), 17'h02);
        wr(8'hff, 8'h00);
        rd(8'hff);
        chk(17'(rd_data[2:0]), 17'(PAGE_SHARED));
        wr(8'h02, 8'hf8);
        rd(8'h02);
        chk(17'(rd_data & 8'h07), 17'h01);
    endtask

    // manual boost, monitor off at once, then back to adaptive
    task automatic t_manual();
        wr(8'hff, 8'h04);
        wr(8'h31, 8'h0c);
        wr(8'h3e, 8'h00);
        repeat (10) @(posedge clk);
        chk(17'(eq_boost_q), 17'h0c);
        chk(17'(eye_monitor_en), 17'h0);
        rd(8'h31);
        chk(17'(rd_data), 17'h0c);
        wr(8'h3e, 8'h80);
        wr(8'h31, 8'h80);
    endtask

    task automatic t_bypass();
        rate_supported <= 1'b0;
        repeat (3) @(posedge clk);
        chk(17'(reclock_bypass_q), 17'h1);
        chk(17'(cdr_lock_q), 17'h0);
        rate_supported <= 1'b1;
        wait_lock();
        chk(17'(eq_boost_q), 17'h09);
        chk(17'(reclock_bypass_q), 17'h0);
    endtask

    // main sequence
    initial
    begin
        n_mismatch = 0;
        samples_checked = 0;
        cycles = 0;
        t_straps();
        do_reset(STRAP_F);
        t_adaptive();
        t_pages();
        t_manual();
        t_bypass();
        complete_run();
    end
endmodule // prc_config_top_bench

// ---- bench/prc_host_model.sv ----
// prc_host_model: serial register host that frames 17-bit transfers toward the block
`timescale 1ns/10ps
module prc_host_model
(
    // clock
    input  wire logic clk,
    // serial pins
    output logic      sck,
    output logic      ss_n,
    output logic      mosi,
    input  wire logic miso
);
    // one frame, msb first; the reply bit is taken just before each sck rise
    task automatic xfer(input logic [16:0] tx, output logic [16:0] rx);
        ss_n <= 1'b0;
        repeat (2) @(posedge clk);
        for (int i = 16; i >= 0; i--)
        begin
            mosi <= tx[i];
            @(posedge clk);
            rx[i] = miso;
            sck <= 1'b1;
            repeat (2) @(posedge clk);
            sck <= 1'b0;
            repeat (3) @(posedge clk);
        end
        // released data line flips so a stale bit is never mistaken for data
        ss_n <= 1'b1;
        mosi <= ~mosi;
        repeat (4) @(posedge clk);
    endtask

    // idle levels: no frame, clock still
    initial
    begin
        sck  = 1'b0;
        ss_n = 1'b1;
        mosi = 1'b0;
    end
endmodule // prc_host_model

// ---- include/prc_pkg.sv ----
// prc_pkg: shared constants and types of the paged reclocker configuration block
package prc_pkg;

    // clock and timing
    localparam int unsigned CLK_PERIOD_NS   = 5;
    localparam int unsigned EQ_DWELL_NS     = 1000;   // settle time per boost step
    localparam int unsigned EQ_DWELL_CYCLES = (EQ_DWELL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // serial frame
    localparam int unsigned SPI_FRAME_BITS  = 17;
    localparam int unsigned SPI_CNT_W       = 5;

    // register offsets
    localparam logic [7:0] ADDR_PAGE_SELECT         = 8'hff;
    localparam logic [7:0] ADDR_EYE_MONITOR_CONTROL = 8'h3e;   // equalizer page
    localparam logic [7:0] ADDR_EQ_CONTROL          = 8'h31;   // equalizer page
    localparam logic [7:0] ADDR_LINK_STATUS         = 8'h02;   // shared page, read only

    // page codes
    localparam logic [2:0] PAGE_SHARED = 3'h0;
    localparam logic [2:0] PAGE_EQ     = 3'h4;
    localparam logic [2:0] PAGE_DRIVER = 3'h5;
    localparam logic [2:0] PAGE_RESET  = PAGE_SHARED;

    // field positions and reset values
    localparam int unsigned EYE_MON_EN_BIT     = 7;
    localparam int unsigned EQ_ADAPTIVE_BIT    = 7;
    localparam int unsigned BOOST_W            = 5;
    localparam logic [7:0]  EYE_MONITOR_RESET  = 8'h80;
    localparam logic [7:0]  EQ_CONTROL_RESET   = 8'h80;
    localparam int unsigned STAT_LOCK_BIT      = 0;
    localparam int unsigned STAT_BYPASS_BIT    = 1;
    localparam int unsigned STAT_SMBUS_BIT     = 2;

    // four-level strap reading
    typedef enum logic [1:0] {STRAP_L, STRAP_R, STRAP_F, STRAP_H} prc_strap_type;

    // equalizer adaptation states
    typedef enum logic [2:0] {EQ_IDLE, EQ_DWELL, EQ_APPLY, EQ_LOCKED, EQ_MANUAL} prc_eq_state_type;

    // map a page code to a storage index; valid low for unused codes
    function automatic logic [2:0] prc_page_index(input logic [2:0] page);
        case (page)
            PAGE_SHARED: prc_page_index = 3'h4;
            PAGE_EQ:     prc_page_index = 3'h5;
            PAGE_DRIVER: prc_page_index = 3'h6;
            default:     prc_page_index = 3'h0;
        endcase
    endfunction

    // register port runs serially when the select strap floats or is high
    function automatic logic prc_strap_is_spi(input prc_strap_type s);
        prc_strap_is_spi = (s == STRAP_F) || (s == STRAP_H);
    endfunction

endpackage

// ---- include/prc_reg_if.sv ----
// prc_reg_if: register access path between the serial engine and the register bank
`timescale 1ns/10ps
interface prc_reg_if;
    logic       wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;

    modport engine (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport bank   (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// ---- logic/prc_config_top.sv ----
// prc_config_top: paged register bank, straps and equalizer adaptation of the reclocking driver
`timescale 1ns/10ps

// Function
// - page field 0xff[2:0]; code 000 is the shared page and the reset page
// - writing 100 to the page field targets the equalizer and recovery page
// - writing 101 to the page field targets the output driver page
// - adaptive mode sweeps boost, keeps best eye score, then asserts lock
// - 0x3e[7] clear disables eye monitor; lock once declared is kept
// - manual mode uses the programmed boost and never needs the eye monitor
// - unsupported input rate forces reclocker bypass and drops lock
// - interface strap floating selects serial port, tied low selects two-wire access
// - high loop-back strap disables the loop-back output
// - low second-cable strap enables the second cable output
// - interface strap F or H gives serial port; L or R gives two-wire access
module prc_config_top
    import prc_pkg::*;
#(
    parameter int unsigned DWELL_CYCLES = EQ_DWELL_CYCLES,
    parameter int unsigned PAGE_DEPTH   = 256
)
(
    // clock and reset
    input  wire logic          clk,
    input  wire logic          rst_n,
    // strap levels
    input  wire prc_strap_type interface_select_strap,
    input  wire prc_strap_type loopback_output_select_strap,
    input  wire prc_strap_type second_cable_select_strap,
    // serial register port
    input  wire logic          sck,
    input  wire logic          ss_n,
    input  wire logic          mosi,
    output logic               miso,
    output logic               miso_oe_n,
    // analogue front end
    input  wire logic [7:0]    eye_score,
    input  wire logic          eye_score_valid,
    input  wire logic          rate_supported,
    // controls and status
    output logic [BOOST_W-1:0] eq_boost_q,
    output logic               eye_monitor_en,
    output logic               cdr_lock_q,
    output logic               reclock_bypass_q,
    output logic               smbus_mode_q,
    output logic               loopback_output_en_q,
    output logic               second_cable_output_en_q
);

    localparam int unsigned DW_W = $clog2(DWELL_CYCLES + 1);

    prc_reg_if reg_bus ();

    logic [2:0]         page_q,    page_d;
    logic [7:0]         eye_mon_q, eye_mon_d;
    logic [7:0]         eq_ctl_q,  eq_ctl_d;
    logic [7:0]         mem_q [0:2][0:PAGE_DEPTH-1];
    logic               mem_we;
    logic [1:0]         mem_pg;
    logic [2:0]         wr_idx, rd_idx;
    logic               strap_done_q, strap_done_d;
    logic               smbus_d, loop_en_d, cab2_en_d;
    prc_eq_state_type   st_q, st_d;
    logic [DW_W-1:0]    dw_q, dw_d;
    logic [BOOST_W-1:0] boost_d, best_q, best_d;
    logic [7:0]         best_score_q, best_score_d;
    logic               lock_d, bypass_d, adaptive, mon_en;

    // serial engine is held off while the two-wire interface owns the registers
    prc_spi_engine u_spi (
        .clk         (clk),
        .rst_n       (rst_n),
        .enable      (strap_done_q && !smbus_mode_q),
        .sck         (sck),
        .ss_n        (ss_n),
        .mosi        (mosi),
        .miso_q      (miso),
        .miso_oe_n_q (miso_oe_n),
        .regs        (reg_bus.engine)
    );

    assign eye_monitor_en = eye_mon_q[EYE_MON_EN_BIT];
    assign adaptive       = eq_ctl_q[EQ_ADAPTIVE_BIT];
    assign mon_en         = eye_mon_q[EYE_MON_EN_BIT];
    assign wr_idx         = prc_page_index(page_q);
    assign rd_idx         = prc_page_index(page_q);
    assign mem_pg         = wr_idx[1:0] - 2'h0;

    // read mux; the page field answers from every page
    always_comb
    begin
        reg_bus.rd_data = 8'h00;
        if (reg_bus.rd_addr == ADDR_PAGE_SELECT)
            reg_bus.rd_data = {5'h00, page_q};
        else if (page_q == PAGE_EQ && reg_bus.rd_addr == ADDR_EYE_MONITOR_CONTROL)
            reg_bus.rd_data = eye_mon_q;
        else if (page_q == PAGE_EQ && reg_bus.rd_addr == ADDR_EQ_CONTROL)
            reg_bus.rd_data = eq_ctl_q;
        else if (page_q == PAGE_SHARED && reg_bus.rd_addr == ADDR_LINK_STATUS)
            reg_bus.rd_data = {5'h00, smbus_mode_q, reclock_bypass_q, cdr_lock_q};
        else if (rd_idx[2])
            reg_bus.rd_data = mem_q[rd_idx[1:0]][reg_bus.rd_addr];
    end

    // register writes steered by the active page; unused page codes drop writes
    always_comb
    begin
        page_d    = page_q;
        eye_mon_d = eye_mon_q;
        eq_ctl_d  = eq_ctl_q;
        mem_we    = 1'b0;
        if (reg_bus.wr_en)
        begin
            if (reg_bus.wr_addr == ADDR_PAGE_SELECT)
                page_d = reg_bus.wr_data[2:0];
            else if (page_q == PAGE_EQ && reg_bus.wr_addr == ADDR_EYE_MONITOR_CONTROL)
                eye_mon_d = reg_bus.wr_data;
            else if (page_q == PAGE_EQ && reg_bus.wr_addr == ADDR_EQ_CONTROL)
                eq_ctl_d = reg_bus.wr_data;
            else if (page_q == PAGE_SHARED && reg_bus.wr_addr == ADDR_LINK_STATUS)
                mem_we = 1'b0;                                                  // status is read only
            else
                mem_we = wr_idx[2];
        end
    end

    // straps are caught once, on the first edge after reset release
    always_comb
    begin
        strap_done_d = 1'b1;
        smbus_d      = smbus_mode_q;
        loop_en_d    = loopback_output_en_q;
        cab2_en_d    = second_cable_output_en_q;
        if (!strap_done_q)
        begin
            smbus_d   = !prc_strap_is_spi(interface_select_strap);
            loop_en_d = (loopback_output_select_strap != STRAP_H);
            cab2_en_d = (second_cable_select_strap == STRAP_L);
        end
    end

    // equalizer adaptation; locking is held once reached, monitor or not
    always_comb
    begin
        st_d         = st_q;
        dw_d         = dw_q;
        boost_d      = eq_boost_q;
        best_d       = best_q;
        best_score_d = best_score_q;
        lock_d       = cdr_lock_q;
        bypass_d     = !rate_supported;
        case (st_q)
            EQ_IDLE:
            begin
                lock_d = 1'b0;
                if (rate_supported && adaptive && mon_en)
                begin
                    boost_d      = '0;
                    best_d       = '0;
                    best_score_d = 8'h00;
                    dw_d         = '0;
                    st_d         = EQ_DWELL;
                end
                else if (rate_supported && !adaptive)
                    st_d = EQ_MANUAL;
            end
            EQ_DWELL:
            begin
                if (!rate_supported || !adaptive)
                    st_d = EQ_IDLE;
                else if (mon_en)                                                // a disabled monitor stalls the sweep
                begin
                    if (dw_q == DW_W'(DWELL_CYCLES - 1))
                    begin
                        dw_d = '0;
                        if (eye_score_valid && eye_score > best_score_q)
                        begin
                            best_d       = eq_boost_q;
                            best_score_d = eye_score;
                        end
                        if (&eq_boost_q)
                            st_d = EQ_APPLY;
                        else
                            boost_d = eq_boost_q + BOOST_W'(1);
                    end
                    else
                        dw_d = dw_q + DW_W'(1);
                end
            end
            EQ_APPLY:
            begin
                boost_d = best_q;
                lock_d  = rate_supported;
                st_d    = rate_supported ? EQ_LOCKED : EQ_IDLE;
            end
            EQ_LOCKED:
            begin
                if (!rate_supported || !adaptive)
                begin
                    lock_d = 1'b0;
                    st_d   = EQ_IDLE;
                end
            end
            EQ_MANUAL:
            begin
                boost_d = eq_ctl_q[BOOST_W-1:0];
                lock_d  = rate_supported && !adaptive;
                if (!rate_supported || adaptive)
                    st_d = EQ_IDLE;
            end
            default:
            begin
                st_d   = EQ_IDLE;
                lock_d = 1'b0;
            end
        endcase
        if (!rate_supported)
            lock_d = 1'b0;
    end

    // state registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            page_q                   <= PAGE_RESET;
            eye_mon_q                <= EYE_MONITOR_RESET;
            eq_ctl_q                 <= EQ_CONTROL_RESET;
            strap_done_q             <= 1'b0;
            smbus_mode_q             <= 1'b0;
            loopback_output_en_q     <= 1'b0;
            second_cable_output_en_q <= 1'b0;
            st_q                     <= EQ_IDLE;
            dw_q                     <= '0;
            eq_boost_q               <= '0;
            best_q                   <= '0;
            best_score_q             <= 8'h00;
            cdr_lock_q               <= 1'b0;
            reclock_bypass_q         <= 1'b1;
        end
        else
        begin
            page_q                   <= page_d;
            eye_mon_q                <= eye_mon_d;
            eq_ctl_q                 <= eq_ctl_d;
            strap_done_q             <= strap_done_d;
            smbus_mode_q             <= smbus_d;
            loopback_output_en_q     <= loop_en_d;
            second_cable_output_en_q <= cab2_en_d;
            st_q                     <= st_d;
            dw_q                     <= dw_d;
            eq_boost_q               <= boost_d;
            best_q                   <= best_d;
            best_score_q             <= best_score_d;
            cdr_lock_q               <= lock_d;
            reclock_bypass_q         <= bypass_d;
        end
    end

    // page storage has no reset; software owns its contents
    always_ff @(posedge clk)
    begin
        if (mem_we)
            mem_q[mem_pg][reg_bus.wr_addr] <= reg_bus.wr_data;
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_page_write(logic [2:0] code);
        reg_bus.wr_en && reg_bus.wr_addr == ADDR_PAGE_SELECT && reg_bus.wr_data[2:0] == code;
    endsequence

    sequence s_sweep_done;
        st_q == EQ_APPLY && rate_supported;
    endsequence

    a_page_reset_shared: assert property (!$past(rst_n) |-> page_q == PAGE_SHARED)
        else $error("page not shared after reset");
    a_page_eq_select: assert property (s_page_write(PAGE_EQ) |=> page_q == PAGE_EQ)
        else $error("equalizer page not selected");
    a_page_drv_select: assert property (s_page_write(PAGE_DRIVER) |=> page_q == PAGE_DRIVER)
        else $error("driver page not selected");
    a_page_any_reach: assert property (reg_bus.wr_en && reg_bus.wr_addr == ADDR_PAGE_SELECT
        |=> page_q == $past(reg_bus.wr_data[2:0]))
        else $error("page field not reachable");
    a_adapt_best_lock: assert property (s_sweep_done |=> cdr_lock_q && eq_boost_q == $past(best_q))
        else $error("adaptive lock not at best boost");
    a_lock_held_mon: assert property (cdr_lock_q && st_q == EQ_LOCKED && adaptive && rate_supported
        && !mon_en |=> cdr_lock_q)
        else $error("lock lost after monitor disabled");
    a_manual_boost_use: assert property (st_q == EQ_MANUAL && rate_supported && !adaptive
        |=> eq_boost_q == $past(eq_ctl_q[BOOST_W-1:0]) && cdr_lock_q)
        else $error("manual boost not applied");
    a_rate_bypass: assert property (!rate_supported |=> reclock_bypass_q && !cdr_lock_q)
        else $error("unsupported rate not bypassed");
    a_strap_if_mode: assert property (strap_done_q && !$past(strap_done_q)
        |-> smbus_mode_q == !prc_strap_is_spi($past(interface_select_strap)))
        else $error("interface strap misread");
    a_strap_loopback: assert property (strap_done_q && !$past(strap_done_q)
        |-> loopback_output_en_q == ($past(loopback_output_select_strap) != STRAP_H))
        else $error("loop-back strap misread");
    a_strap_cable2: assert property (strap_done_q && !$past(strap_done_q)
        |-> second_cable_output_en_q == ($past(second_cable_select_strap) == STRAP_L))
        else $error("second cable strap misread");
    a_mon_follows_reg: assert property (reg_bus.wr_en && page_q == PAGE_EQ
        && reg_bus.wr_addr == ADDR_EYE_MONITOR_CONTROL |=> eye_monitor_en == $past(reg_bus.wr_data[7]))
        else $error("eye monitor enable not updated");

endmodule // prc_config_top

// ---- logic/prc_spi_engine.sv ----
// prc_spi_engine: 17-bit serial frame shifter that turns frames into register accesses
`timescale 1ns/10ps
module prc_spi_engine
    import prc_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // mode
    input  wire logic       enable,
    // serial pins
    input  wire logic       sck,
    input  wire logic       ss_n,
    input  wire logic       mosi,
    output logic            miso_q,
    output logic            miso_oe_n_q,
    // register side
    prc_reg_if.engine       regs
);

    logic [16:0]          sr_q,    sr_d;
    logic [SPI_CNT_W-1:0] cnt_q,   cnt_d;
    logic                 sck_p_q, ss_p_q;
    logic                 miso_d,  oe_n_d;
    logic                 wr_q,    wr_d;
    logic [7:0]           waddr_q, waddr_d;
    logic [7:0]           wdata_q, wdata_d;
    logic                 sck_rise, sck_fall, ss_rise, ss_fall, full;

    // pins are synchronous to clk, so one stored copy is enough for edge detection
    assign sck_rise = sck && !sck_p_q;
    assign sck_fall = !sck && sck_p_q;
    assign ss_rise  = ss_n && !ss_p_q;
    assign ss_fall  = !ss_n && ss_p_q;
    assign full     = (cnt_q >= SPI_CNT_W'(SPI_FRAME_BITS));

    assign regs.wr_en   = wr_q;
    assign regs.wr_addr = waddr_q;
    assign regs.wr_data = wdata_q;
    assign regs.rd_addr = sr_q[15:8];

    // frame shifting; previous frame content leaves on miso so chained parts work
    always_comb
    begin
        sr_d    = sr_q;
        cnt_d   = cnt_q;
        miso_d  = miso_q;
        oe_n_d  = !(enable && !ss_n);
        wr_d    = 1'b0;
        waddr_d = waddr_q;
        wdata_d = wdata_q;
        if (enable && ss_fall)
        begin
            cnt_d  = '0;
            miso_d = sr_q[16];
        end
        else if (enable && !ss_n && sck_rise)
        begin
            sr_d = {sr_q[15:0], mosi};
            if (!full)
                cnt_d = cnt_q + SPI_CNT_W'(1);
        end
        else if (enable && !ss_n && sck_fall)
            miso_d = sr_q[16];
        else if (enable && ss_rise && full)
        begin
            // a longer frame still acts on its last 17 bits
            if (!sr_q[16])
            begin
                wr_d    = 1'b1;
                waddr_d = sr_q[15:8];
                wdata_d = sr_q[7:0];
            end
            else
                sr_d = {1'b1, sr_q[15:8], regs.rd_data};   // answer goes out in the next frame
        end
    end

    // state registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sr_q        <= '0;
            cnt_q       <= '0;
            sck_p_q     <= 1'b0;
            ss_p_q      <= 1'b1;
            miso_q      <= 1'b0;
            miso_oe_n_q <= 1'b1;
            wr_q        <= 1'b0;
            waddr_q     <= '0;
            wdata_q     <= '0;
        end
        else
        begin
            sr_q        <= sr_d;
            cnt_q       <= cnt_d;
            sck_p_q     <= sck;
            ss_p_q      <= ss_n;
            miso_q      <= miso_d;
            miso_oe_n_q <= oe_n_d;
            wr_q        <= wr_d;
            waddr_q     <= waddr_d;
            wdata_q     <= wdata_d;
        end
    end

endmodule // prc_spi_engine
